// ===== tb/dis_ctl_model.sv
// Controller model: pulses the load strobe, gates and clocks the chain.
// Assumes the bench clock; link clock idles low between frames.
`timescale 1ns/1ps
module dis_ctl_model (
    // Clock and returned data
    input  wire logic          i_mclk,
    input  wire logic          i_sop,
    // Link strobes
    output dis_pkg::dis_link_t o_link
);
    initial o_link = '{1'b1, 1'b1, 1'b0, 1'b0};
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // One frame: load, then 16 shifts at 80 ns
    task automatic frame(input logic gate_n, input logic [15:0] sin,
                         output logic [15:0] got);
        o_link.parallel_capture_n = 1'b0;
        tick(3);
        o_link.parallel_capture_n = 1'b1;
        tick(4);
        o_link.shift_gate_n = gate_n;
        tick(4);
        for (int i = 15; i >= 0; i--) begin
            got[i] = i_sop;
            o_link.serial_chain_in = sin[i];
            tick(1);
            o_link.shift_clk = 1'b1;
            tick(5);
            o_link.shift_clk = 1'b0;
            tick(4);
        end
        o_link.shift_gate_n = 1'b1;
        o_link.serial_chain_in = ~sin[0];
        tick(4);
    endtask
endmodule

// ===== tb/dis_serializer_sva.sv
// Port checker for the debounced input serializer.
// Assumes a bind onto dis_serializer, one clock, synchronous reset.
`timescale 1ns/1ps
module dis_serializer_sva (
    // Clock, reset and inputs
    input wire logic       i_mclk,
    input wire logic       i_srst,
    input wire logic [7:0] i_field_in,
    input wire logic       i_debounce_sel_lo,
    input wire logic       i_debounce_sel_hi,
    input wire logic       i_parallel_capture_n,
    input wire logic       i_shift_gate_n,
    input wire logic       i_shift_clk,
    input wire logic       i_temp_warn,
    input wire logic       i_temp_shdn,
    // Outputs
    input wire logic       o_serial_chain_out,
    input wire logic       o_serial_chain_out_oe_n,
    input wire logic       o_overtemp_flag_n,
    input wire logic       o_overtemp_flag_n_oe_n,
    input wire logic [7:0] o_filtered_channel_bits
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Cycles since field or high select bit (sel_hi) last moved
    logic [19:0] quiet = '0;
    always_ff @(posedge i_mclk) begin
        if ($changed(i_field_in) || $changed(i_debounce_sel_hi))
            quiet <= '0;
        else
            quiet <= quiet + 20'h0_0001;
    end
    warn_flag_a: assert property (i_temp_warn [*4] |-> !o_overtemp_flag_n)
        else $error("flag not low on warning");
    shdn_float_a: assert property (i_temp_shdn [*4] |->
        o_serial_chain_out_oe_n && o_overtemp_flag_n_oe_n)
        else $error("outputs still driven in shutdown");
    shdn_low_a: assert property (i_temp_shdn [*4] |-> !o_overtemp_flag_n)
        else $error("flag not low in shutdown");
    drive_a: assert property (!i_temp_shdn [*4] |-> !o_serial_chain_out_oe_n)
        else $error("chain output released while cool");
    hold_a: assert property ((i_parallel_capture_n && i_shift_gate_n) [*6]
        |-> $stable(o_serial_chain_out)) else $error("register moved on hold");
    load_a: assert property (
        (!i_parallel_capture_n && $stable(o_filtered_channel_bits)) [*5]
        |-> o_serial_chain_out == o_filtered_channel_bits[7])
        else $error("load did not show top channel");
    bypass_a: assert property (
        (!i_debounce_sel_hi && i_debounce_sel_lo && $stable(i_field_in)) [*5]
        |-> o_filtered_channel_bits == i_field_in) else $error("bypass lag");
    slow_a: assert property (i_debounce_sel_hi &&
        $changed(o_filtered_channel_bits) |-> quiet > 20'h1_E460)
        else $error("level accepted before interval");
    cover property (!i_parallel_capture_n ##1 i_parallel_capture_n);
    cover property (!i_shift_gate_n && $rose(i_shift_clk));
    cover property (i_temp_shdn [*4]);
endmodule

// ===== tb/tb_dis_serializer.sv
// Self-checking bench for the debounced input serializer.
// Assumes the controller model and checker sit beside the design.
`timescale 1ns/1ps
module tb_dis_serializer;
    typedef struct packed {
        logic [7:0]  f;
        logic        g;
        logic [15:0] s;
    } dis_row_t;
    localparam dis_row_t ROWS [4] = '{'{8'hA5, 1'b0, 16'h3C96},
        '{8'h5A, 1'b0, 16'hF00F}, '{8'hC3, 1'b1, 16'h1234},
        '{8'h0F, 1'b0, 16'hA5A5}};
    logic mclk, srst, slo, shi, warn, shdn, sop, sop_oe, flg, flg_oe;
    logic [7:0] fld, filt;
    logic [15:0] got;
    dis_pkg::dis_link_t link;
    int n_fail = 0;
    int n_checks = 0;
    dis_serializer dis_serializer_i (.i_mclk(mclk), .i_srst(srst),
        .i_field_in(fld), .i_debounce_sel_lo(slo), .i_debounce_sel_hi(shi),
        .i_parallel_capture_n(link.parallel_capture_n),
        .i_shift_gate_n(link.shift_gate_n), .i_shift_clk(link.shift_clk),
        .i_serial_chain_in(link.serial_chain_in), .i_temp_warn(warn),
        .i_temp_shdn(shdn), .o_serial_chain_out(sop),
        .o_serial_chain_out_oe_n(sop_oe), .o_overtemp_flag_n(flg),
        .o_overtemp_flag_n_oe_n(flg_oe), .o_filtered_channel_bits(filt));
    dis_ctl_model dis_ctl_model_i (.i_mclk(mclk), .i_sop(sop), .o_link(link));
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {srst, slo, shi, warn, shdn, fld} = {5'b11000, 8'h00};
        tick(20);
        check("reset", 16'({sop, sop_oe, flg, flg_oe, filt}), 16'h0200);
        srst = 1'b0;
        foreach (ROWS[k]) begin
            fld = ROWS[k].f;
            tick(6);
            check("filt", 16'(filt), 16'(ROWS[k].f));
            dis_ctl_model_i.frame(ROWS[k].g, ROWS[k].s, got);
            check("frame", got, ROWS[k].g ? {16{ROWS[k].f[7]}} :
                {ROWS[k].f, ROWS[k].s[15:8]});
            $display("row %0d done", k);
        end
        {shi, slo} = 2'b10;
        tick(6);
        fld = 8'hF0;
        tick(200);
        check("slow", 16'(filt), 16'h000F);
        {shi, slo} = 2'b01;
        tick(6);
        check("bypass", 16'(filt), 16'h00F0);
        $display("debounce test done");
        warn = 1'b1;
        tick(6);
        check("warn", 16'({flg, flg_oe, sop_oe}), 16'h0000);
        shdn = 1'b1;
        tick(6);
        check("shdn", 16'({flg, flg_oe, sop_oe}), 16'h0003);
        {warn, shdn} = 2'b00;
        tick(6);
        check("cool", 16'({flg, flg_oe, sop_oe}), 16'h0004);
        $display("thermal test done");
        fld = 8'h3C;
        tick(6);
        dis_ctl_model_i.frame(1'b0, 16'h0000, got);
        check("pair", 16'({got[15] & got[14], got[13] & got[12],
            got[11] & got[10], got[9] & got[8]}), 16'h0006);
        check("pair_eq", 16'({got[15] ^ got[14], got[13] ^ got[12],
            got[11] ^ got[10], got[9] ^ got[8]}), 16'h0000);
        $display("paired channel test done");
        summarize();
    end
endmodule
bind dis_serializer dis_serializer_sva dis_serializer_sva_i (.*);

// ===== verilog/dis_pkg.sv
// Package for the debounced input serializer: constants and carriers.
// Assumes a single 125 MHz system clock and synchronous active-high reset.
package dis_pkg;

    // ****************************************
    // Clock and time base
    // ****************************************
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned TICK_W        = 7;
    localparam int unsigned DB_LONG_MS    = 3;
    localparam int unsigned DB_SHORT_MS   = 1;
    localparam int unsigned DB_LONG_TICKS = DB_LONG_MS * 1000 / TICK_US;
    localparam int unsigned DB_SHORT_TICKS = DB_SHORT_MS * 1000 / TICK_US;
    localparam int unsigned DB_W          = 12;

    // ****************************************
    // Channels and chain
    // ****************************************
    localparam int unsigned NCH   = 8;
    localparam int unsigned LAST  = NCH - 1;

    // ****************************************
    // Debounce select codes (sel_hi, sel_lo), 1 = open
    // ****************************************
    localparam logic [1:0] SEL_3MS    = 2'h3;
    localparam logic [1:0] SEL_1MS    = 2'h2;
    localparam logic [1:0] SEL_BYPASS = 2'h1;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic parallel_capture_n;
        logic shift_gate_n;
        logic shift_clk;
        logic serial_chain_in;
    } dis_link_t;

    typedef struct packed {
        logic [1:0] data;
        logic [1:0] valid;
        logic       rd;
        logic       wr;
    } dis_buf_t;

endpackage

// ===== verilog/dis_serializer.sv
// Debounced eight-channel input serializer with serial shift interface.
// Assumes field inputs, link strobes and thermal levels are asynchronous.
`timescale 1ns/1ps

module dis_serializer (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_srst,
    // Field inputs and debounce selection
    input  wire logic [7:0]       i_field_in,
    input  wire logic             i_debounce_sel_lo,
    input  wire logic             i_debounce_sel_hi,
    // Serial link from the controller
    input  wire logic             i_parallel_capture_n,
    input  wire logic             i_shift_gate_n,
    input  wire logic             i_shift_clk,
    input  wire logic             i_serial_chain_in,
    // Temperature sensor trip levels
    input  wire logic             i_temp_warn,
    input  wire logic             i_temp_shdn,
    // Serial output pin
    output logic                  o_serial_chain_out,
    output logic                  o_serial_chain_out_oe_n,
    // Over-temperature flag pin
    output logic                  o_overtemp_flag_n,
    output logic                  o_overtemp_flag_n_oe_n,
    // Filtered states for status drivers
    output logic [7:0]            o_filtered_channel_bits
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]              f1;
        logic [7:0]              f2;
        dis_pkg::dis_link_t      l1;
        dis_pkg::dis_link_t      l2;
        logic                    clk_d;
        logic [1:0]              t1;
        logic [1:0]              t2;
        logic [1:0]              s1;
        logic [1:0]              s2;
        logic [dis_pkg::TICK_W-1:0] tick_cnt;
        logic                    tick;
        logic [7:0]              filt;
        logic [7:0][dis_pkg::DB_W-1:0] cnt;
        logic [7:0]              sreg;
        logic                    out_bit;
        logic                    out_oe_n;
        logic                    flag_n;
        logic                    flag_oe_n;
    } dis_state_t;

    dis_state_t st;
    dis_state_t next_st;

    logic [dis_pkg::DB_W-1:0] db_limit;
    logic                     bypass;
    logic                     clk_rise;

    // ****************************************
    // Debounce interval selection
    // ****************************************
    always_comb begin
        bypass   = 1'b0;
        db_limit = dis_pkg::DB_W'(dis_pkg::DB_LONG_TICKS);
        unique case (st.s2)
            dis_pkg::SEL_3MS: db_limit = dis_pkg::DB_W'(dis_pkg::DB_LONG_TICKS);
            dis_pkg::SEL_1MS: db_limit = dis_pkg::DB_W'(dis_pkg::DB_SHORT_TICKS);
            dis_pkg::SEL_BYPASS: bypass = 1'b1;
            default: db_limit = dis_pkg::DB_W'(dis_pkg::DB_LONG_TICKS);
        endcase
    end

    assign clk_rise = st.l2.shift_clk & ~st.clk_d;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        // Two-flop synchronisers
        next_st.f1 = i_field_in;
        next_st.f2 = st.f1;
        next_st.l1 = '{i_parallel_capture_n, i_shift_gate_n,
                       i_shift_clk, i_serial_chain_in};
        next_st.l2 = st.l1;
        next_st.clk_d = st.l2.shift_clk;
        next_st.t1 = {i_temp_shdn, i_temp_warn};
        next_st.t2 = st.t1;
        next_st.s1 = {i_debounce_sel_hi, i_debounce_sel_lo};
        next_st.s2 = st.s1;

        // Microsecond time base
        next_st.tick = 1'b0;
        if (st.tick_cnt == dis_pkg::TICK_W'(dis_pkg::TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
        end

        // Per-channel filters
        for (int i = 0; i < dis_pkg::NCH; i++) begin
            if (bypass) begin
                next_st.filt[i] = st.f2[i];
                next_st.cnt[i]  = '0;
            end else if (st.f2[i] == st.filt[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.tick) begin
                if (st.cnt[i] + 1'b1 >= db_limit) begin
                    next_st.filt[i] = st.f2[i];
                    next_st.cnt[i]  = '0;
                end else begin
                    next_st.cnt[i] = st.cnt[i] + 1'b1;
                end
            end
        end

        // Shift register
        if (!st.l2.parallel_capture_n) begin
            next_st.sreg = st.filt;
        end else if (!st.l2.shift_gate_n && clk_rise) begin
            next_st.sreg = {st.sreg[dis_pkg::LAST-1:0],
                            st.l2.serial_chain_in};
        end
        // Otherwise held

        next_st.out_bit = next_st.sreg[dis_pkg::LAST];

        // Thermal flag and output release
        next_st.flag_n    = ~(st.t2[0] | st.t2[1]);
        next_st.out_oe_n  = st.t2[1];
        next_st.flag_oe_n = st.t2[1];
        if (st.t2[1]) begin
            next_st.flag_n = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st           <= '0;
            st.l1        <= '{1'b1, 1'b1, 1'b0, 1'b0};
            st.l2        <= '{1'b1, 1'b1, 1'b0, 1'b0};
            st.flag_n    <= 1'b1;
            st.out_oe_n  <= 1'b0;
            st.flag_oe_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_serial_chain_out      = st.out_bit;
    assign o_serial_chain_out_oe_n = st.out_oe_n;
    assign o_overtemp_flag_n       = st.flag_n;
    assign o_overtemp_flag_n_oe_n  = st.flag_oe_n;
    assign o_filtered_channel_bits = st.filt;

endmodule
